// File: dv/cpu_model.sv
// ==========================================================
// Bus-side CPU model: byte-wide register access over APB
module cpu_model import tmr_pkg::*; (
  // Clock
  input  wire logic        clk,
  // APB request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  // APB answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  logic        err   = 1'b0;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // One byte access; request held until pready is seen high
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    // No wait limit here: the bench timeout ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // High byte goes to the shared latch first
  task automatic wr16(input logic [7:0] ah, input logic [7:0] al, input logic [15:0] v);
    logic [7:0] q;
    acc(1'b1, ah, v[15:8], q);
    acc(1'b1, al, v[7:0], q);
  endtask

  // No interrupt code here, so the pair is never split
  task automatic rd16(input logic [7:0] al, input logic [7:0] ah, output logic [15:0] v);
    acc(1'b0, al, 8'h00, v[7:0]);
    acc(1'b0, ah, 8'h00, v[15:8]);
  endtask
endmodule

// File: dv/timer16_with_byte_access_tb.sv
module timer16_with_byte_access_tb import tmr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic        CLK = 1'b0;
  logic        RSTN = 1'b0;
  logic        EXT_COUNT_PIN = 1'b0;
  logic        CAPTURE_PIN = 1'b0;
  wire logic   psel, penable, pwrite, pready, pslverr;
  wire logic   i_ovf, i_a, i_b, i_c, oc_a, oc_b;
  wire logic [7:0]  paddr;
  wire logic [31:0] pwdata, prdata;
  int          fails = 0;
  int          n_compared = 0;
  int          cyc = 0;
  logic [7:0]  q;
  logic [15:0] v, w;

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end

  always #5 CLK = ~CLK;

  timer16 uut (.CLK(CLK), .RSTN(RSTN), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EXT_COUNT_PIN(EXT_COUNT_PIN), .CAPTURE_PIN(CAPTURE_PIN), .COMPARE_OUTPUT_PIN_A(oc_a),
    .COMPARE_OUTPUT_PIN_B(oc_b), .IRQ_OVF(i_ovf), .IRQ_CMPA(i_a), .IRQ_CMPB(i_b), .IRQ_CAP(i_c));

  cpu_model cpu (.clk(CLK), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Whole run needs well under this
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      end_sim();
    end
  end

  initial begin
    repeat (3) @(posedge CLK);
    RSTN <= 1'b1;
    // ==========================================================
    // Reset values and byte pairing, timer stopped
    cpu.rd16(ADDR_CNT_L, ADDR_CNT_H, v);
    `CHK("count", 16'h0000, v)
    cpu.rd16(ADDR_CMPA_L, ADDR_CMPA_H, v);
    `CHK("cmp_a", 16'h0000, v)
    cpu.wr16(ADDR_CNT_H, ADDR_CNT_L, 16'h01FF);
    cpu.rd16(ADDR_CNT_L, ADDR_CNT_H, v);
    `CHK("count", 16'h01FF, v)
    cpu.wr16(ADDR_CMPA_H, ADDR_CMPA_L, 16'h1234);
    cpu.acc(1'b1, ADDR_CNT_H, 8'hAB, q);
    cpu.rd16(ADDR_CMPA_L, ADDR_CMPA_H, v);
    `CHK("cmp_a", 16'h1234, v)
    cpu.acc(1'b0, ADDR_CNT_H, 8'h00, q);
    `CHK("latch", 8'hAB, q)
    cpu.acc(1'b0, 8'h3C, 8'h00, q);
    `CHK("slverr", 1'b1, cpu.err)
    $display("test byte_access done");
    // ==========================================================
    // Capture through filter; short glitch must not capture
    cpu.acc(1'b1, ADDR_CTRL_B, 8'hC0, q);
    cpu.acc(1'b1, ADDR_IRQ_MASK, 8'h20, q);
    @(posedge CLK) CAPTURE_PIN <= 1'b1;
    repeat (16) @(posedge CLK);
    `CHK("irq_cap", 1'b1, i_c)
    cpu.rd16(ADDR_CAP_L, ADDR_CAP_H, v);
    `CHK("capture", 16'h01FF, v)
    cpu.acc(1'b0, ADDR_IRQ_FLAG, 8'h00, q);
    `CHK("flags", 8'h20, q)
    cpu.acc(1'b1, ADDR_IRQ_FLAG, 8'h20, q);
    @(posedge CLK) CAPTURE_PIN <= 1'b0;
    repeat (2) @(posedge CLK);
    CAPTURE_PIN <= 1'b1;
    repeat (16) @(posedge CLK);
    cpu.acc(1'b0, ADDR_IRQ_FLAG, 8'h00, q);
    `CHK("flags", 8'h00, q)
    $display("test capture done");
    // ==========================================================
    // Overflow and compare match while counting
    cpu.wr16(ADDR_CMPA_H, ADDR_CMPA_L, 16'h0005);
    cpu.wr16(ADDR_CMPB_H, ADDR_CMPB_L, 16'h8000);
    cpu.wr16(ADDR_CNT_H, ADDR_CNT_L, 16'hFFFE);
    cpu.acc(1'b1, ADDR_IRQ_MASK, 8'h01, q);
    // Channel A toggles on match, channel B sets on match
    cpu.acc(1'b1, ADDR_CTRL_A, 8'h70, q);
    cpu.acc(1'b1, ADDR_CTRL_B, {5'h00, CS_DIV1}, q);
    repeat (30) @(posedge CLK);
    cpu.acc(1'b1, ADDR_CTRL_B, 8'h00, q);
    `CHK("irq_ovf", 1'b1, i_ovf)
    `CHK("irq_cmpa", 1'b0, i_a)
    `CHK("irq_cmpb", 1'b0, i_b)
    `CHK("oc_a", 1'b1, oc_a)
    `CHK("oc_b", 1'b0, oc_b)
    cpu.acc(1'b1, ADDR_CTRL_C, 8'h40, q);
    @(posedge CLK);
    `CHK("oc_b", 1'b1, oc_b)
    cpu.acc(1'b0, ADDR_IRQ_FLAG, 8'h00, q);
    `CHK("flags", 8'h03, q)
    cpu.acc(1'b1, ADDR_IRQ_FLAG, 8'h03, q);
    cpu.acc(1'b0, ADDR_IRQ_FLAG, 8'h00, q);
    `CHK("flags", 8'h00, q)
    `CHK("irq_ovf", 1'b0, i_ovf)
    $display("test count done");
    // ==========================================================
    // Power-off bit freezes the counter
    cpu.acc(1'b1, ADDR_POWER, 8'h01, q);
    cpu.acc(1'b1, ADDR_CTRL_B, {5'h00, CS_DIV1}, q);
    cpu.rd16(ADDR_CNT_L, ADDR_CNT_H, v);
    repeat (5) @(posedge CLK);
    cpu.rd16(ADDR_CNT_L, ADDR_CNT_H, w);
    `CHK("frozen", v, w)
    cpu.acc(1'b1, ADDR_POWER, 8'h00, q);
    cpu.rd16(ADDR_CNT_L, ADDR_CNT_H, w);
    `CHK("running", 1'b1, w != v)
    $display("test power done");
    // ==========================================================
    // External pin rising edges as tick
    cpu.acc(1'b1, ADDR_CTRL_B, 8'h00, q);
    cpu.wr16(ADDR_CNT_H, ADDR_CNT_L, 16'h0000);
    cpu.acc(1'b1, ADDR_CTRL_B, {5'h00, CS_EXT_RISE}, q);
    repeat (3) begin
      @(posedge CLK) EXT_COUNT_PIN <= 1'b1;
      repeat (4) @(posedge CLK);
      EXT_COUNT_PIN <= 1'b0;
      repeat (3) @(posedge CLK);
    end
    repeat (6) @(posedge CLK);
    cpu.acc(1'b1, ADDR_CTRL_B, 8'h00, q);
    cpu.rd16(ADDR_CNT_L, ADDR_CNT_H, v);
    `CHK("ext_count", 16'h0003, v)
    $display("test ext_pin done");
    // ==========================================================
    // CTC with TOP from compare A, prescaled; then compare-A TOP in PWM
    cpu.wr16(ADDR_CMPA_H, ADDR_CMPA_L, 16'h0003);
    cpu.wr16(ADDR_CNT_H, ADDR_CNT_L, 16'h0000);
    cpu.acc(1'b1, ADDR_IRQ_FLAG, 8'h27, q);
    cpu.acc(1'b1, ADDR_CTRL_B, 8'h0A, q);
    repeat (200) @(posedge CLK);
    cpu.acc(1'b1, ADDR_CTRL_B, 8'h08, q);
    cpu.rd16(ADDR_CNT_L, ADDR_CNT_H, v);
    `CHK("ctc_top", 1'b1, v <= 16'h0003)
    cpu.acc(1'b0, ADDR_IRQ_FLAG, 8'h00, q);
    `CHK("ctc_flags", 8'h02, q)
    cpu.acc(1'b1, ADDR_CTRL_A, 8'hF0, q);
    cpu.acc(1'b1, ADDR_CTRL_C, 8'h80, q);
    @(posedge CLK);
    `CHK("oc_a", 1'b1, oc_a)
    cpu.acc(1'b1, ADDR_CTRL_A, 8'hF3, q);
    cpu.acc(1'b1, ADDR_CTRL_B, 8'h19, q);
    repeat (20) @(posedge CLK);
    `CHK("pwm_a_off", 1'b0, oc_a)
    cpu.acc(1'b1, ADDR_CTRL_B, 8'h00, q);
    $display("test modes done");
    end_sim();
  end
endmodule

// File: hw/pin_conditioner.sv
module pin_conditioner import tmr_pkg::*; (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Pin side
  input  wire logic pin,
  input  wire logic filt_en,
  // Clean level
  output logic      level
);

  logic                    meta_q;
  logic                    sync_q;
  logic                    level_q;
  logic [FILT_SAMPLES-1:0] hist_q;

  wire all_hi = &hist_q;
  wire all_lo = ~|hist_q;

  // ==========================================================
  // Two-stage synchroniser, then optional majority-free filter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q  <= 1'b0;
      sync_q  <= 1'b0;
      hist_q  <= '0;
      level_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      hist_q <= {hist_q[FILT_SAMPLES-2:0], sync_q};
      if (!filt_en) begin
        level_q <= sync_q;
      end else if (all_hi) begin
        level_q <= 1'b1;
      end else if (all_lo) begin
        level_q <= 1'b0;
      end
    end
  end

  assign level = level_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_FILTER_STEADY: assert property (
    (filt_en && $past(filt_en) && level_q != $past(level_q)) |-> $past(all_hi || all_lo)
  ) else $error("filtered level moved without four equal samples");

endmodule

// File: hw/timer16.sv
// Functional notes
// - 16-bit registers byte-paired, control bytes free
// - Every source flagged and individually maskable
// - Tick from prescaler or pin; none stops
// - Buffered compares compared on each tick except the first after a count write, drive outputs
// - Compare match sets its channel flag
// - Capture edge copies count, optional filter first
// - TOP from fixed values, compare A, capture
// - Compare-A TOP buffered in PWM modes only, channel A PWM off
// - BOTTOM is 0000, MAX is FFFF
// - One shared high-byte latch per timer
// - Low write loads latch plus low byte
// - Count or capture low read copies high byte into latch
// - Compare reads bypass the latch entirely
// - Count write beats clear or count
// - Overflow flag set where mode defines
// - Capture flag set with capture copy
// - Filter needs four equal samples
module timer16 import tmr_pkg::*; (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RSTN,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Pins
  input  wire logic        EXT_COUNT_PIN,
  input  wire logic        CAPTURE_PIN,
  output logic             COMPARE_OUTPUT_PIN_A,
  output logic             COMPARE_OUTPUT_PIN_B,
  // Interrupt requests
  output logic             IRQ_OVF,
  output logic             IRQ_CMPA,
  output logic             IRQ_CMPB,
  output logic             IRQ_CAP
);

  logic [7:0]  ctrl_a_q, ctrl_b_q, power_q, mask_q, flag_q, temp_q;
  logic [7:0]  flag_d, mask_d, temp_d, rbyte;
  logic [15:0] count_value_q, count_value_d;
  logic [15:0] cmpa_buf_q, cmpb_buf_q, cmpa_q, cmpb_q, cap_q;
  logic [15:0] top_val;
  logic [9:0]  pre_q;
  logic [31:0] prdata_q;
  logic [3:0]  irq_q;
  logic        pready_q, pslverr_q, oca_q, ocb_q, blk_q;
  logic        ext_prev_q, cap_prev_q, ext_lvl, cap_lvl, tick;
  logic        dual, pwm;
  dir_t        dir_q, dir_d;
  top_src_t    top_sel;

  // ==========================================================
  // APB decode: one wait state; writes act on completion edge, low-read latch copy one edge earlier
  wire acc_prep = PSEL & PENABLE & ~pready_q;
  wire acc_done = PSEL & PENABLE & pready_q;
  wire sel_ca   = PADDR == ADDR_CTRL_A;
  wire sel_cb   = PADDR == ADDR_CTRL_B;
  wire sel_cc   = PADDR == ADDR_CTRL_C;
  wire sel_cl   = PADDR == ADDR_CNT_L;
  wire sel_ch   = PADDR == ADDR_CNT_H;
  wire sel_al   = PADDR == ADDR_CMPA_L;
  wire sel_ah   = PADDR == ADDR_CMPA_H;
  wire sel_bl   = PADDR == ADDR_CMPB_L;
  wire sel_bh   = PADDR == ADDR_CMPB_H;
  wire sel_il   = PADDR == ADDR_CAP_L;
  wire sel_ih   = PADDR == ADDR_CAP_H;
  wire sel_fl   = PADDR == ADDR_IRQ_FLAG;
  wire sel_mk   = PADDR == ADDR_IRQ_MASK;
  wire sel_pw   = PADDR == ADDR_POWER;
  wire addr_ok  = |{sel_ca, sel_cb, sel_cc, sel_cl, sel_ch, sel_al, sel_ah,
                    sel_bl, sel_bh, sel_il, sel_ih, sel_fl, sel_mk, sel_pw};
  wire wr_done  = acc_done & PWRITE & addr_ok;
  wire rd_prep  = acc_prep & ~PWRITE & addr_ok;
  wire [7:0] wbyte = PWDATA[7:0];
  wire wr_cnt   = wr_done & sel_cl;
  wire [3:0] wgm = {ctrl_b_q[CB_WGM_LSB+1:CB_WGM_LSB], ctrl_a_q[CA_WGM_LSB+1:CA_WGM_LSB]};
  wire [2:0] cs  = ctrl_b_q[CB_CS_LSB+2:CB_CS_LSB];
  wire active    = ~power_q[PWR_OFF];
  wire top_a     = top_sel == TOP_CMPA;
  wire top_cap   = top_sel == TOP_CAP;

  always_comb begin
    unique case (1'b1)
      sel_ca:  rbyte = ctrl_a_q;
      sel_cb:  rbyte = ctrl_b_q;
      sel_cl:  rbyte = count_value_q[7:0];
      sel_al:  rbyte = cmpa_buf_q[7:0];
      sel_ah:  rbyte = cmpa_buf_q[15:8];
      sel_bl:  rbyte = cmpb_buf_q[7:0];
      sel_bh:  rbyte = cmpb_buf_q[15:8];
      sel_il:  rbyte = cap_q[7:0];
      sel_ch, sel_ih: rbyte = temp_q;
      sel_fl:  rbyte = flag_q;
      sel_mk:  rbyte = mask_q;
      sel_pw:  rbyte = power_q;
      default: rbyte = 8'h00;
    endcase
  end

  // ==========================================================
  // Mode decode: TOP source, slope and PWM
  always_comb begin
    dual = 1'b0;
    pwm  = 1'b0;
    unique case (wgm)
      4'h1: begin top_sel = TOP_FIX8;  dual = 1'b1; pwm = 1'b1; end
      4'h2: begin top_sel = TOP_FIX9;  dual = 1'b1; pwm = 1'b1; end
      4'h3: begin top_sel = TOP_FIX10; dual = 1'b1; pwm = 1'b1; end
      4'h4: top_sel = TOP_CMPA;
      4'h5: begin top_sel = TOP_FIX8;  pwm = 1'b1; end
      4'h6: begin top_sel = TOP_FIX9;  pwm = 1'b1; end
      4'h7: begin top_sel = TOP_FIX10; pwm = 1'b1; end
      4'h8, 4'hA: begin top_sel = TOP_CAP;  dual = 1'b1; pwm = 1'b1; end
      4'h9, 4'hB: begin top_sel = TOP_CMPA; dual = 1'b1; pwm = 1'b1; end
      4'hC: top_sel = TOP_CAP;
      4'hE: begin top_sel = TOP_CAP;  pwm = 1'b1; end
      4'hF: begin top_sel = TOP_CMPA; pwm = 1'b1; end
      default: top_sel = TOP_MAX;
    endcase
  end

  always_comb begin
    unique case (top_sel)
      TOP_FIX8:  top_val = TOP_8BIT;
      TOP_FIX9:  top_val = TOP_9BIT;
      TOP_FIX10: top_val = TOP_10BIT;
      TOP_CMPA:  top_val = cmpa_q;
      TOP_CAP:   top_val = cap_q;
      default:   top_val = CNT_MAX;
    endcase
  end

  // ==========================================================
  // Pin conditioning and timer tick
  pin_conditioner u_ext (
    .clk     (CLK),
    .rstn    (RSTN),
    .pin     (EXT_COUNT_PIN),
    .filt_en (1'b0),
    .level   (ext_lvl)
  );

  pin_conditioner u_cap (
    .clk     (CLK),
    .rstn    (RSTN),
    .pin     (CAPTURE_PIN),
    .filt_en (ctrl_b_q[CB_FILT]),
    .level   (cap_lvl)
  );

  always_comb begin
    unique case (cs)
      CS_DIV1:     tick = 1'b1;
      CS_DIV8:     tick = (pre_q & PRE_M8) == PRE_M8;
      CS_DIV64:    tick = (pre_q & PRE_M64) == PRE_M64;
      CS_DIV256:   tick = (pre_q & PRE_M256) == PRE_M256;
      CS_DIV1024:  tick = pre_q == PRE_M1024;
      CS_EXT_FALL: tick = ext_prev_q & ~ext_lvl;
      CS_EXT_RISE: tick = ~ext_prev_q & ext_lvl;
      default:     tick = 1'b0;
    endcase
    tick = tick & active;
  end

  // ==========================================================
  // Counter unit
  wire at_top = count_value_q == top_val;
  wire at_bot = count_value_q == CNT_BOTTOM;
  wire up     = dir_q == DIR_UP;

  always_comb begin
    count_value_d = count_value_q;
    dir_d         = dual ? dir_q : DIR_UP;
    if (wr_cnt) begin
      count_value_d = {temp_q, wbyte};
    end else if (tick && dual) begin
      if (up && at_top) begin
        dir_d         = DIR_DOWN;
        count_value_d = count_value_q - 16'h0001;
      end else if (!up && at_bot) begin
        dir_d         = DIR_UP;
        count_value_d = count_value_q + 16'h0001;
      end else begin
        count_value_d = up ? count_value_q + 16'h0001 : count_value_q - 16'h0001;
      end
    end else if (tick) begin
      count_value_d = at_top ? CNT_BOTTOM : count_value_q + 16'h0001;
    end
  end

  // ==========================================================
  // Events: matches are suppressed on the tick after a count write
  wire match_a = tick & ~blk_q & (count_value_q == cmpa_q);
  wire match_b = tick & ~blk_q & (count_value_q == cmpb_q);
  wire ovf_ev  = tick & (pwm ? (dual ? (~up & at_bot) : at_top)
                             : (count_value_q == CNT_MAX));
  wire cap_edge = ctrl_b_q[CB_EDGE] ? (cap_lvl & ~cap_prev_q) : (~cap_lvl & cap_prev_q);
  wire cap_ev  = active & ~top_cap & cap_edge;
  wire frc_a   = wr_done & sel_cc & wbyte[CC_FORCE_A] & ~pwm;
  wire frc_b   = wr_done & sel_cc & wbyte[CC_FORCE_B] & ~pwm;
  wire [7:0] ev_v  = {2'b00, cap_ev, 2'b00, match_b, match_a, ovf_ev};
  wire [7:0] clr_v = (wr_done & sel_fl) ? wbyte : 8'h00;

  // Set wins over a write-one clear in the same cycle
  assign flag_d = ((flag_q & ~clr_v) | ev_v) & FLAG_USED;
  assign mask_d = (wr_done & sel_mk) ? (wbyte & FLAG_USED) : mask_q;

  always_comb begin
    temp_d = temp_q;
    if (wr_done && (sel_ch || sel_ah || sel_bh || sel_ih)) begin
      temp_d = wbyte;
    end else if (rd_prep && sel_cl) begin
      temp_d = count_value_q[15:8];
    end else if (rd_prep && sel_il) begin
      temp_d = cap_q[15:8];
    end
  end

  // ==========================================================
  // Waveform generator
  function automatic logic oc_next(input logic cur, input logic [1:0] com,
                                   input logic hit, input logic wrap,
                                   input logic pwm_m, input logic dual_m,
                                   input logic up_m);
    logic v;
    v = cur;
    if (com == 2'b00 || (pwm_m && com == 2'b01)) begin
      v = 1'b0;
    end else if (!pwm_m) begin
      if (hit) v = (com == 2'b01) ? ~cur : com[0];
    end else if (dual_m) begin
      if (hit) v = up_m ? com[0] : ~com[0];
    end else if (hit) begin
      v = com[0];
    end else if (wrap) begin
      v = ~com[0];
    end
    return v;
  endfunction

  wire wrap = tick & at_top;
  wire oca_d = (pwm && top_a) ? 1'b0 :
               oc_next(oca_q, ctrl_a_q[CA_COMA_LSB+1:CA_COMA_LSB],
                       match_a | frc_a, wrap, pwm, dual, up);
  wire ocb_d = oc_next(ocb_q, ctrl_a_q[CA_COMB_LSB+1:CA_COMB_LSB],
                       match_b | frc_b, wrap, pwm, dual, up);

  // ==========================================================
  // Register file and state
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_a_q      <= CTRL_RST;
      ctrl_b_q      <= CTRL_RST;
      power_q       <= POWER_RST;
      mask_q        <= CTRL_RST;
      flag_q        <= CTRL_RST;
      temp_q        <= CTRL_RST;
      count_value_q <= REG16_RST;
      cmpa_buf_q    <= REG16_RST;
      cmpb_buf_q    <= REG16_RST;
      cmpa_q        <= REG16_RST;
      cmpb_q        <= REG16_RST;
      cap_q         <= REG16_RST;
      dir_q         <= DIR_UP;
      pre_q         <= 10'h000;
      blk_q         <= 1'b0;
      ext_prev_q    <= 1'b0;
      cap_prev_q    <= 1'b0;
      oca_q         <= 1'b0;
      ocb_q         <= 1'b0;
      irq_q         <= 4'h0;
    end else begin
      if (wr_done && sel_ca) ctrl_a_q <= wbyte;
      if (wr_done && sel_cb) ctrl_b_q <= wbyte;
      if (wr_done && sel_pw) power_q <= wbyte;
      if (wr_done && sel_al) cmpa_buf_q <= {temp_q, wbyte};
      if (wr_done && sel_bl) cmpb_buf_q <= {temp_q, wbyte};
      // Live compare values reload at TOP in PWM modes, glitch-free
      if (!pwm || wrap) begin
        cmpa_q <= cmpa_buf_q;
        cmpb_q <= cmpb_buf_q;
      end
      if (cap_ev) begin
        cap_q <= count_value_q;
      end else if (wr_done && sel_il && top_cap) begin
        cap_q <= {temp_q, wbyte};
      end
      mask_q        <= mask_d;
      flag_q        <= flag_d;
      temp_q        <= temp_d;
      count_value_q <= count_value_d;
      dir_q         <= dir_d;
      pre_q         <= active ? pre_q + 10'h001 : 10'h000;
      blk_q         <= wr_cnt | (blk_q & ~tick);
      ext_prev_q    <= ext_lvl;
      cap_prev_q    <= cap_lvl;
      oca_q         <= oca_d;
      ocb_q         <= ocb_d;
      irq_q         <= {flag_d[FLAG_CAP], flag_d[FLAG_CMPB], flag_d[FLAG_CMPA],
                        flag_d[FLAG_OVF]} & {mask_d[FLAG_CAP], mask_d[FLAG_CMPB],
                        mask_d[FLAG_CMPA], mask_d[FLAG_OVF]};
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= acc_prep;
      pslverr_q <= acc_prep & ~addr_ok;
      if (acc_prep) prdata_q <= rd_prep ? {24'h00_0000, rbyte} : 32'h0000_0000;
    end
  end

  assign PRDATA               = prdata_q;
  assign PREADY               = pready_q;
  assign PSLVERR              = pslverr_q;
  assign COMPARE_OUTPUT_PIN_A = oca_q;
  assign COMPARE_OUTPUT_PIN_B = ocb_q;
  assign IRQ_OVF              = irq_q[0];
  assign IRQ_CMPA             = irq_q[1];
  assign IRQ_CMPB             = irq_q[2];
  assign IRQ_CAP              = irq_q[3];

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence s_low_read_cnt;
    rd_prep && sel_cl;
  endsequence

  sequence s_match_a;
    tick && !blk_q && count_value_q == cmpa_q;
  endsequence

  AST_CNT_WRITE_WINS: assert property (
    wr_cnt |=> count_value_q == {$past(temp_q), $past(PWDATA[7:0])}
  ) else $error("count write did not load latch and low byte");

  AST_LATCH_ON_LOW_READ: assert property (
    s_low_read_cnt |=> temp_q == $past(count_value_q[15:8]) && PREADY
  ) else $error("low read did not capture high byte");

  AST_CMP_READ_NO_LATCH: assert property (
    (rd_prep && (sel_al || sel_ah || sel_bl || sel_bh)) |=> $stable(temp_q)
  ) else $error("compare read disturbed latch");

  AST_IRQ_LINES: assert property (
    {IRQ_CAP, IRQ_CMPB, IRQ_CMPA, IRQ_OVF} ==
    ({flag_q[FLAG_CAP], flag_q[FLAG_CMPB], flag_q[FLAG_CMPA], flag_q[FLAG_OVF]} &
     {mask_q[FLAG_CAP], mask_q[FLAG_CMPB], mask_q[FLAG_CMPA], mask_q[FLAG_OVF]})
  ) else $error("interrupt line differs from flag and mask");

  AST_STOPPED: assert property (
    (cs == CS_OFF && !wr_cnt) |=> $stable(count_value_q)
  ) else $error("counter moved with no clock source");

  AST_CAPTURE: assert property (
    cap_ev |=> flag_q[FLAG_CAP] && cap_q == $past(count_value_q)
  ) else $error("capture copy and flag not in same cycle");

  AST_CMPA_FLAG: assert property (
    s_match_a |=> flag_q[FLAG_CMPA]
  ) else $error("compare A match did not set flag");

  AST_PWM_A_OFF: assert property (
    (pwm && top_a) [*2] |-> !COMPARE_OUTPUT_PIN_A
  ) else $error("channel A drives PWM while it defines TOP");

  AST_OVF_NORMAL: assert property (
    (tick && !pwm && count_value_q == CNT_MAX) |=> flag_q[FLAG_OVF]
  ) else $error("overflow flag missed at MAX");

  AST_TOP_WRAP: assert property (
    (tick && !dual && at_top && !wr_cnt) |=> count_value_q == CNT_BOTTOM
  ) else $error("single-slope count did not wrap at TOP");

endmodule

// File: hw/tmr_pkg.sv
package tmr_pkg;

  // ==========================================================
  // Register byte addresses (8-bit data in the low lane)
  localparam logic [7:0] ADDR_CTRL_A   = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B   = 8'h04;
  localparam logic [7:0] ADDR_CTRL_C   = 8'h08;
  localparam logic [7:0] ADDR_CNT_L    = 8'h0C;
  localparam logic [7:0] ADDR_CNT_H    = 8'h10;
  localparam logic [7:0] ADDR_CMPA_L   = 8'h14;
  localparam logic [7:0] ADDR_CMPA_H   = 8'h18;
  localparam logic [7:0] ADDR_CMPB_L   = 8'h1C;
  localparam logic [7:0] ADDR_CMPB_H   = 8'h20;
  localparam logic [7:0] ADDR_CAP_L    = 8'h24;
  localparam logic [7:0] ADDR_CAP_H    = 8'h28;
  localparam logic [7:0] ADDR_IRQ_FLAG = 8'h2C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h30;
  localparam logic [7:0] ADDR_POWER    = 8'h34;

  // ==========================================================
  // Field positions
  localparam int CA_WGM_LSB = 0;
  localparam int CA_COMB_LSB = 4;
  localparam int CA_COMA_LSB = 6;
  localparam int CB_CS_LSB = 0;
  localparam int CB_WGM_LSB = 3;
  localparam int CB_EDGE = 6;
  localparam int CB_FILT = 7;
  localparam int CC_FORCE_B = 6;
  localparam int CC_FORCE_A = 7;
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CMPA = 1;
  localparam int FLAG_CMPB = 2;
  localparam int FLAG_CAP = 5;
  localparam int PWR_OFF = 0;
  localparam logic [7:0] FLAG_USED = 8'h27;

  // ==========================================================
  // Reset values and counter landmarks
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [7:0]  POWER_RST  = 8'h00;
  localparam logic [15:0] REG16_RST  = 16'h0000;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT   = 16'h00FF;
  localparam logic [15:0] TOP_9BIT   = 16'h01FF;
  localparam logic [15:0] TOP_10BIT  = 16'h03FF;

  // ==========================================================
  // Clock select codes and prescaler masks (divide by mask+1)
  localparam logic [2:0] CS_OFF      = 3'h0;
  localparam logic [2:0] CS_DIV1     = 3'h1;
  localparam logic [2:0] CS_DIV8     = 3'h2;
  localparam logic [2:0] CS_DIV64    = 3'h3;
  localparam logic [2:0] CS_DIV256   = 3'h4;
  localparam logic [2:0] CS_DIV1024  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [9:0] PRE_M8      = 10'h007;
  localparam logic [9:0] PRE_M64     = 10'h03F;
  localparam logic [9:0] PRE_M256    = 10'h0FF;
  localparam logic [9:0] PRE_M1024   = 10'h3FF;
  localparam int FILT_SAMPLES = 4;

  // ==========================================================
  // Types
  typedef enum logic [4:0] {
    TOP_MAX  = 5'b00001,
    TOP_FIX8 = 5'b00010,
    TOP_FIX9 = 5'b00100,
    TOP_FIX10 = 5'b01000,
    TOP_CMPA = 5'b10000,
    TOP_CAP  = 5'b00000
  } top_src_t;

  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } dir_t;

endpackage
